/* bench/tone_port_assertions.sv */
// Purpose: wire-level checks of the pins between host end and device end
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   sees only interface signals, instantiated beside the interface
`timescale 1ns/10ps
module tone_port_assertions (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       chip_sel_n,
    input wire logic       register_select,
    input wire logic       rw_or_wr_n,
    input wire logic       data_strobe_hi,
    input wire logic [3:0] host_nibble_o,
    input wire logic       host_nibble_oe,
    input wire logic [3:0] dev_nibble_o,
    input wire logic       dev_nibble_oe,
    input wire logic       irq_progress_o,
    input wire logic       irq_progress_oe,
    input wire logic       bus_style
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    // active read or write in either bus style
    sequence rd_act;
        !chip_sel_n && (bus_style ? !data_strobe_hi : (data_strobe_hi && rw_or_wr_n));
    endsequence
    sequence wr_act;
        !chip_sel_n && (bus_style ? !rw_or_wr_n : (data_strobe_hi && !rw_or_wr_n));
    endsequence

    // bus floating and driving
    cs_float_a: assert property (chip_sel_n |-> !dev_nibble_oe)
        else $error("data bus driven while deselected");
    strobe_float_a: assert property ((bus_style ? data_strobe_hi : !data_strobe_hi)
        |-> !dev_nibble_oe)
        else $error("data bus driven without read strobe");
    one_driver_a: assert property (!(host_nibble_oe && dev_nibble_oe))
        else $error("both ends drive the data bus");
    read_drive_a: assert property (rd_act ##1 rd_act |-> dev_nibble_oe)
        else $error("device silent in second read cycle");
    write_data_a: assert property (wr_act |-> host_nibble_oe)
        else $error("host not driving during write strobe");
    // host side pin discipline, plus the device irq open drain check
    select_hold_a: assert property (!chip_sel_n ##1 !chip_sel_n
        |-> $stable(register_select) && $stable(bus_style))
        else $error("register select moved inside an access");
    cs_release_a: assert property (!chip_sel_n |-> ##[1:8] chip_sel_n)
        else $error("chip select held low too long");
    idle_strobe_a: assert property (chip_sel_n && !bus_style |-> !data_strobe_hi)
        else $error("data strobe active outside an access");
    irq_drain_a: assert property (irq_progress_oe |-> !irq_progress_o)
        else $error("irq pin driven high");
endmodule // tone_port_assertions

/* bench/tone_transceiver_host_port_tb_top.sv */
// Purpose: self-checking bench joining host end and device end
// Assumes: short strobe of 2 cycles, seed fixed for repeatable runs
// Notes:   reads never issued while both halves are powered down
`include "tone_port_defs.svh"
`timescale 1ns/10ps
module tone_transceiver_host_port_tb_top;
    import tone_port_pkg::*;
    logic       sys_clk, sys_rst, bus_style, wr, rd, pair_valid, cp_level, burst_done;
    logic       steer, busy, irq_n, early_out, guard_out, guard_oe;
    logic       tone_oe, tx_pd, rx_pd, osc_run;
    logic [1:0] addr, lg, hg;
    logic [7:0] wdata, rdata;
    nibble_t    tx_code;
    int         fails, checks;

    tone_port_if tp();
    tone_host_end #(.STROBE_CYC(2)) tone_host_end_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
        .port(tp), .i_bus_style(bus_style), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_busy(busy), .o_irq_n(irq_n));
    tone_dev_end tone_dev_end_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .port(tp),
        .i_pair_valid(pair_valid), .i_low_group(lg), .i_high_group(hg),
        .i_cp_level(cp_level), .i_burst_done(burst_done), .i_steering_in(steer),
        .o_early_steering_out(early_out), .o_guard_time_out(guard_out),
        .o_guard_time_oe(guard_oe),
        .o_tone_output_oe(tone_oe), .o_tx_code(tx_code), .o_tx_power_down(tx_pd),
        .o_receiver_power_down_bit(rx_pd), .o_osc_run(osc_run));
    tone_port_assertions tone_port_assertions_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
        .chip_sel_n(tp.chip_sel_n), .register_select(tp.register_select),
        .rw_or_wr_n(tp.rw_or_wr_n), .data_strobe_hi(tp.data_strobe_hi),
        .host_nibble_o(tp.host_nibble_o), .host_nibble_oe(tp.host_nibble_oe),
        .dev_nibble_o(tp.dev_nibble_o), .dev_nibble_oe(tp.dev_nibble_oe),
        .irq_progress_o(tp.irq_progress_o), .irq_progress_oe(tp.irq_progress_oe),
        .bus_style(tp.bus_style));

    // 40 MHz clock stands in for the external timebase; no crystal model
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // settle after edges so sampled outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one device access through the host command register, bounded wait
    task automatic cmd(input logic is_read, input logic rs, input nibble_t nib);
        int n;
        @(posedge sys_clk);
        addr  <= 2'h0;
        wdata <= {2'h0, is_read, rs, nib};
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
        n = 0;
        do
        begin
            settle(1);
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (n >= 40) check(busy, 1'b0);
    endtask

    task automatic rdreg(input logic [1:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic rd_dev(input logic rs, output logic [7:0] v);
        cmd(1'b1, rs, 4'h0);
        rdreg(2'h1, v);
    endtask

    // code of a tone pair from row and column index
    function automatic nibble_t exp_code(input logic [1:0] l, input logic [1:0] h);
        if (h == 2'h3)
            return (l == 2'h3) ? 4'h0 : 4'hD + {2'h0, l};
        if (l == 2'h3)
            return (h == 2'h0) ? 4'hB : ((h == 2'h1) ? 4'hA : 4'hC);
        return 4'(l * 3 + h + 1);
    endfunction

    // hang guard, well above the several hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] v, c;
        nibble_t    prev;
        {sys_rst, bus_style, wr, rd, pair_valid, cp_level, burst_done, steer} = 8'h80;
        {addr, lg, hg, wdata} = 14'h0;
        fails = 0;
        checks = 0;
        void'($urandom(32'h7B06));
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle(1);
        check(tone_oe, 1'b0);
        check(tx_pd, 1'b1);
        check({osc_run, guard_oe, guard_out, early_out}, 4'hC);
        // power control in both bus styles, first pass both halves down
        for (int s = 0; s < 2; s++)
        begin
            @(posedge sys_clk);
            bus_style <= s[0];
            for (int k = 0; k < 3; k++)
            begin
                c = (k == 0) ? 8'h02 : 8'($urandom) & 8'h03;
                cmd(1'b0, 1'b1, c[3:0]);
                check(tone_oe, c[0]);
                check(rx_pd, c[1]);
                check(osc_run, !(c[1] && !c[0]));
                check(irq_n, 1'b1);
                if (c[1:0] != 2'h2) rd_dev(1'b1, v);
                if (c[1:0] != 2'h2) check(v[`TP_STAT_RXPD], c[1]);
            end
        end
        // transmit code register, reached with register select low
        c = 8'($urandom);
        cmd(1'b0, `TP_RS_DATA, c[3:0]);
        check(tx_code, c[3:0]);
        // receive path: tone on, interrupt mode, corner digit D first
        cmd(1'b0, 1'b1, 4'h5);
        @(posedge sys_clk);
        pair_valid <= 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            @(posedge sys_clk);
            bus_style <= 1'($urandom);
            lg <= (i == 0) ? 2'h3 : 2'($urandom);
            hg <= (i == 0) ? 2'h3 : 2'($urandom);
            settle(3);
            check(early_out, 1'b1);
            if (i > 0) rd_dev(1'b0, v);
            if (i > 0) check(v[3:0], prev);
            @(posedge sys_clk);
            steer <= 1'b0;
            settle(3);
            check({early_out, guard_oe}, 2'h2);
            @(posedge sys_clk);
            steer <= 1'b1;
            settle(4);
            check({guard_oe, guard_out, irq_n}, 3'h6);
            rd_dev(1'b0, v);
            prev = exp_code(lg, hg);
            check(v[3:0], prev);
            check(irq_n, 1'b1);
        end
        // one-cycle loss of the pair
        @(posedge sys_clk);
        pair_valid <= 1'b0;
        @(posedge sys_clk);
        pair_valid <= 1'b1;
        #1;
        check({early_out, guard_oe, guard_out}, 3'h2);
        @(posedge sys_clk);
        steer <= 1'b0;
        // transmit burst done raises the interrupt until status is read
        @(posedge sys_clk);
        burst_done <= 1'b1;
        @(posedge sys_clk);
        burst_done <= 1'b0;
        settle(2);
        check(irq_n, 1'b0);
        rd_dev(1'b1, v);
        check({v[`TP_STAT_TXDONE], irq_n}, 2'h3);
        // call progress mode: irq follows the filtered input
        cmd(1'b0, 1'b1, 4'h8);
        for (int j = 0; j < 6; j++)
        begin
            @(posedge sys_clk);
            cp_level <= j[0];
            settle(3);
            check(irq_n, j[0]);
        end
        // refused write to an unmapped address, unmapped read, idle busy bit
        @(posedge sys_clk);
        addr  <= 2'h2;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
        settle(1);
        check(busy, 1'b0);
        rdreg(2'h3, v);
        check(v, 8'h00);
        rdreg(2'h0, v);
        check(v, 8'h00);
        give_verdict();
    end
endmodule // tone_transceiver_host_port_tb_top

/* rtl/tone_dev_end.sv */
// Purpose: device end of the tone transceiver host port
// Assumes: pins synchronous to i_sys_clk; detector and burst logic outside
// Notes:   bus style 0 = level r/w with data strobe, 1 = separate strobes
//
// Overview of operation
// - tone pin floats when tone enable low
// - data bus floats outside an active read
// - interrupt mode pulls irq low on burst
// - progress mode irq follows filtered input
// - early steering high on valid pair
// - early steering low on loss of pair
// - steering rising registers pair, updates latch
// - steering low rearms for new pair
// - guard output from early steering, steering
// - host gates chip select with qualifier
// - host toggles chip select every access
// - direction pin: level or write strobe
// - host strobes only during accesses
// - register select decoded with direction
// - timebase from crystal or external clock
// - transmitter, receiver power down separately
// - registered pair latched as 4-bit code
// - irq low while delayed steering flag
// - guard driven high while early steering and steering high
// - both down: tristate bus, irq, tone pins, stop oscillator
`include "tone_port_defs.svh"
`timescale 1ns/10ps
module tone_dev_end (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_sys_rst,
    tone_port_if.dev                   port,
    input  wire logic                  i_pair_valid,
    input  wire logic [1:0]            i_low_group,
    input  wire logic [1:0]            i_high_group,
    input  wire logic                  i_cp_level,
    input  wire logic                  i_burst_done,
    input  wire logic                  i_steering_in,
    output logic                       o_early_steering_out,
    output logic                       o_guard_time_out,
    output logic                       o_guard_time_oe,
    output logic                       o_tone_output_oe,
    output tone_port_pkg::nibble_t     o_tx_code,
    output logic                       o_tx_power_down,
    output logic                       o_receiver_power_down_bit,
    output logic                       o_osc_run
);
    import tone_port_pkg::*;

    typedef struct packed {
        logic [3:0] ctrl;
        nibble_t    tx_code;
        nibble_t    rx_code;
        nibble_t    rd_nibble;
        nibble_t    wr_nibble;
        logic       wr_sel;
        logic       dsteer;
        logic       txdone;
        logic       early;
        logic       armed;
        logic       steer_prev;
        logic       wr_prev;
        logic       rd_prev;
    } dev_state_s;

    dev_state_s state_reg;
    dev_state_s state_next;

    logic       rd_act;
    logic       wr_act;
    logic       rx_pd;
    logic       tx_pd;
    logic       all_pd;
    logic       reg_pair;
    logic       irq_cause;
    logic       status_rd;
    logic       data_rd;
    logic [3:0] status_nib;

    // pair code: row-major digit numbering, with 0, *, #, A..D, D wrapping
    function automatic nibble_t pair_code(input logic [1:0] lo, input logic [1:0] hi);
        logic [3:0] k;
        k = 4'h0;
        if (hi == 2'h3)
            k = (lo == 2'h3) ? 4'h0 : 4'(4'hD + {2'h0, lo});
        else if (lo == 2'h3)
            k = (hi == 2'h0) ? 4'hB : ((hi == 2'h1) ? 4'hA : 4'hC);
        else
            k = 4'(lo * 3 + hi + 1);
        return k;
    endfunction

    // access decode for both bus styles; chip select always qualifies
    always_comb
    begin
        if (port.bus_style)
        begin
            rd_act = !port.chip_sel_n && !port.data_strobe_hi;
            wr_act = !port.chip_sel_n && !port.rw_or_wr_n;
        end
        else
        begin
            rd_act = !port.chip_sel_n && port.data_strobe_hi && port.rw_or_wr_n;
            wr_act = !port.chip_sel_n && port.data_strobe_hi && !port.rw_or_wr_n;
        end
    end

    // power control from the control register
    assign tx_pd  = !state_reg.ctrl[`TP_CTRL_TONE_EN];
    assign rx_pd  = state_reg.ctrl[`TP_CTRL_RX_PD];
    assign all_pd = tx_pd && rx_pd;

    // a read ends on the strobe falling away; that is when flags clear,
    // so a flag set in either of the last two strobe cycles can vanish before the host has latched it
    assign status_rd = state_reg.rd_prev && !rd_act && (state_reg.wr_sel == `TP_RS_CTRL);
    assign data_rd   = state_reg.rd_prev && !rd_act && (state_reg.wr_sel == `TP_RS_DATA);
    assign reg_pair  = !rx_pd && i_steering_in && !state_reg.steer_prev
                       && state_reg.armed && state_reg.early;

    // next state
    always_comb
    begin
        state_next         = state_reg;
        state_next.rd_prev = rd_act;
        state_next.wr_prev = wr_act;
        state_next.steer_prev = i_steering_in;
        state_next.early      = i_pair_valid && !rx_pd;
        // latch address and data during the strobe, commit at its end
        if (rd_act || wr_act)
            state_next.wr_sel = port.register_select;
        if (wr_act)
            state_next.wr_nibble = port.host_nibble_o;
        if (state_reg.wr_prev && !wr_act)
        begin
            if (state_reg.wr_sel == `TP_RS_CTRL)
                state_next.ctrl = state_reg.wr_nibble;
            else
                state_next.tx_code = state_reg.wr_nibble;
        end
        // read data from flops: receive latch or status
        if (port.register_select == `TP_RS_DATA)
            state_next.rd_nibble = state_reg.rx_code;
        else
            state_next.rd_nibble = status_nib;
        // steering: rearm once below threshold
        if (!i_steering_in)
            state_next.armed = 1'b1;
        // clears first so that a same-cycle set wins
        if (data_rd)
            state_next.dsteer = 1'b0;
        if (status_rd)
            state_next.txdone = 1'b0;
        if (reg_pair)
        begin
            state_next.rx_code = pair_code(i_low_group, i_high_group);
            state_next.dsteer  = 1'b1;
            state_next.armed   = 1'b0;
        end
        if (i_burst_done && !tx_pd)
            state_next.txdone = 1'b1;
    end

    // status nibble seen at register select 1 on reads
    always_comb
    begin
        status_nib                = 4'h0;
        status_nib[`TP_STAT_IRQ]    = irq_cause;
        status_nib[`TP_STAT_TXDONE] = state_reg.txdone;
        status_nib[`TP_STAT_DSTEER] = state_reg.dsteer;
        status_nib[`TP_STAT_RXPD]   = rx_pd;
    end

    assign irq_cause = state_reg.dsteer || state_reg.txdone;

    // open drain irq: only ever drives low
    always_comb
    begin
        port.irq_progress_o  = 1'b0;
        port.irq_progress_oe = 1'b0;
        if (!all_pd)
        begin
            if (state_reg.ctrl[`TP_CTRL_CP_MODE])
                port.irq_progress_oe = !rx_pd && !i_cp_level;
            else if (state_reg.ctrl[`TP_CTRL_IRQ_EN])
                port.irq_progress_oe = irq_cause;
        end
    end

    // data bus only driven inside a read; floats otherwise
    assign port.dev_nibble_o  = state_reg.rd_nibble;
    assign port.dev_nibble_oe = rd_act && state_reg.rd_prev && !all_pd;

    // guard: drive low while no pair (resets the rc), drive high once
    // threshold reached with pair held, float while rc charges
    assign o_guard_time_out = state_reg.early;
    assign o_guard_time_oe  = !state_reg.early || i_steering_in;

    assign o_early_steering_out      = state_reg.early;
    assign o_tone_output_oe          = !tx_pd;
    assign o_tx_code                 = state_reg.tx_code;
    assign o_tx_power_down           = tx_pd;
    assign o_receiver_power_down_bit = rx_pd;
    assign o_osc_run                 = !all_pd;

    // one register for all state
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg      <= '0;
            state_reg.ctrl <= `TP_CTRL_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule // tone_dev_end

/* rtl/tone_host_end.sv */
// Purpose: host end: turns register commands into pin bus cycles
// Assumes: single clock; one device access at a time
// Notes:   chip select released between accesses
`include "tone_port_defs.svh"
`timescale 1ns/10ps
module tone_host_end #(
    parameter int STROBE_CYC = `TP_STROBE_CYC
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_sys_rst,
    tone_port_if.host                  port,
    input  wire logic                  i_bus_style,
    input  wire logic [1:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [7:0]                 o_rdata,
    output logic                       o_busy,
    output logic                       o_irq_n
);
    import tone_port_pkg::*;

    typedef struct packed {
        host_state_e state;
        logic [7:0]  cnt;
        logic        rs;
        logic        rd;
        nibble_t     wnib;
        nibble_t     rnib;
        logic [7:0]  rdata;
        logic        style;
    } host_state_s;

    host_state_s state_reg;
    host_state_s state_next;
    logic        strobe_on;
    logic        sel_on;

    // command intake and bus sequencing
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = 8'h00;
        if (i_rd)
        begin
            if (i_addr == `TP_H_CMD)
                state_next.rdata = {7'h00, state_reg.state != H_IDLE};
            else if (i_addr == `TP_H_RDATA)
                state_next.rdata = {4'h0, state_reg.rnib};
        end
        unique case (state_reg.state)
            H_IDLE:
            begin
                // commands while busy are dropped
                if (i_wr && i_addr == `TP_H_CMD)
                begin
                    state_next.rs    = i_wdata[`TP_CMD_RS];
                    state_next.rd    = i_wdata[`TP_CMD_READ];
                    state_next.wnib  = i_wdata[3:0];
                    state_next.style = i_bus_style;
                    state_next.state = H_SETUP;
                end
            end
            H_SETUP:
            begin
                state_next.cnt   = 8'(STROBE_CYC - 1);
                state_next.state = H_STROBE;
            end
            H_STROBE:
            begin
                if (state_reg.cnt == 8'h00)
                begin
                    if (state_reg.rd)
                        state_next.rnib = port.dev_nibble_o;
                    state_next.state = H_HOLD;
                end
                else
                    state_next.cnt = state_reg.cnt - 8'h01;
            end
            H_HOLD:
                state_next.state = H_IDLE;
        endcase
    end

    assign strobe_on = state_reg.state == H_STROBE;
    assign sel_on    = state_reg.state != H_IDLE;

    // pins; style fixed for the whole access
    always_comb
    begin
        port.bus_style       = state_reg.style;
        port.chip_sel_n      = !sel_on;
        port.register_select = state_reg.rs;
        port.host_nibble_o   = state_reg.wnib;
        port.host_nibble_oe  = sel_on && !state_reg.rd;
        if (state_reg.style)
        begin
            port.rw_or_wr_n     = !(strobe_on && !state_reg.rd);
            port.data_strobe_hi = !(strobe_on && state_reg.rd);
        end
        else
        begin
            port.rw_or_wr_n     = state_reg.rd;
            port.data_strobe_hi = strobe_on;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_busy  = sel_on;
    assign o_irq_n = !port.irq_progress_oe;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

endmodule // tone_host_end

/* rtl/tone_port_defs.svh */
// Purpose: constants of the tone transceiver host port
// Assumes: 40 MHz system clock
// Notes:   offsets are register select values
`ifndef TONE_PORT_DEFS_SVH
`define TONE_PORT_DEFS_SVH
`define TP_CLK_NS        25
`define TP_STROBE_NS     100
`define TP_STROBE_CYC    ((`TP_STROBE_NS + `TP_CLK_NS - 1) / `TP_CLK_NS)
`define TP_RS_DATA       1'h0
`define TP_RS_CTRL       1'h1
`define TP_CTRL_TONE_EN  0
`define TP_CTRL_RX_PD    1
`define TP_CTRL_IRQ_EN   2
`define TP_CTRL_CP_MODE  3
`define TP_CTRL_RST      4'h0
`define TP_STAT_IRQ      0
`define TP_STAT_TXDONE   1
`define TP_STAT_DSTEER   2
`define TP_STAT_RXPD     3
`define TP_H_CMD         2'h0
`define TP_H_RDATA       2'h1
`define TP_CMD_RS        4
`define TP_CMD_READ      5
`endif

/* rtl/tone_port_if.sv */
// Purpose: pins between the tone transceiver and its host
// Assumes: two-way pins kept as value and enable pairs, read unresolved by both ends
// Notes:   irq and guard pins are open drain / tristate style
`timescale 1ns/10ps
interface tone_port_if;
    logic       chip_sel_n;
    logic       register_select;
    logic       rw_or_wr_n;
    logic       data_strobe_hi;
    logic [3:0] host_nibble_o;
    logic       host_nibble_oe;
    logic [3:0] dev_nibble_o;
    logic       dev_nibble_oe;
    logic       irq_progress_o;
    logic       irq_progress_oe;
    logic       bus_style;
    modport dev (
        input  chip_sel_n, register_select, rw_or_wr_n, data_strobe_hi,
        input  host_nibble_o, host_nibble_oe, bus_style,
        output dev_nibble_o, dev_nibble_oe, irq_progress_o, irq_progress_oe
    );
    modport host (
        output chip_sel_n, register_select, rw_or_wr_n, data_strobe_hi,
        output host_nibble_o, host_nibble_oe, bus_style,
        input  dev_nibble_o, dev_nibble_oe, irq_progress_o, irq_progress_oe
    );
endinterface // tone_port_if

/* rtl/tone_port_pkg.sv */
// Purpose: shared types of the tone transceiver host port
// Assumes: constants come from tone_port_defs.svh
// Notes:   host bus sequencer states
package tone_port_pkg;
    typedef logic [3:0] nibble_t;
    typedef enum logic [1:0] {
        H_IDLE   = 2'b00,
        H_SETUP  = 2'b01,
        H_STROBE = 2'b10,
        H_HOLD   = 2'b11
    } host_state_e;
endpackage
